//--- design/capture_pkg.sv
package capture_pkg;

  // ****************************************************************
  // state identifiers shown to software
  // ****************************************************************
  localparam logic [3:0] ID_IDLE        = 4'h0;
  localparam logic [3:0] ID_ARMING      = 4'h1;
  localparam logic [3:0] ID_FLASH_DELAY = 4'h3;
  localparam logic [3:0] ID_CAPTURING   = 4'h7;
  localparam logic [3:0] ID_REPEAT      = 4'hb;
  localparam logic [3:0] ID_PAUSED      = 4'h6;
  localparam logic [3:0] ID_WINDING     = 4'h4;
  localparam logic [3:0] ID_RESUME      = 4'h5;
  localparam logic [3:0] ID_PRE_FINAL   = 4'he;
  localparam logic [3:0] ID_FINAL_FRAME = 4'hf;
  localparam logic [3:0] ID_FINAL_PAUSE = 4'hd;

  // ****************************************************************
  // scaling modes and widths
  // ****************************************************************
  localparam logic [1:0] SCALE_NONE    = 2'h0;
  localparam logic [1:0] SCALE_SAMPLE  = 2'h1;
  localparam logic [1:0] SCALE_AVERAGE = 2'h2;

  localparam int COORD_W    = 11;
  localparam int PIX_W      = 24;
  localparam int CHAN_W     = 8;
  localparam int SUM_W      = 11;
  localparam int RATE_W     = 4;
  localparam int DELAY_W    = 8;
  localparam int FIFO_DEPTH = 16;

  // ****************************************************************
  // capture control states, one-hot
  // ****************************************************************
  typedef enum logic [10:0] {
    idle_state           = 11'h001,
    arming_state         = 11'h002,
    flash_delay_state    = 11'h004,
    capturing_state      = 11'h008,
    repeat_capture_state = 11'h010,
    paused_state         = 11'h020,
    winding_down_state   = 11'h040,
    resume_state         = 11'h080,
    pre_final_state      = 11'h100,
    final_frame_state    = 11'h200,
    final_pause_state    = 11'h400
  } capture_state_t;

endpackage

//--- design/pixel_fifo_if.sv
`timescale 1ns/1ns
interface pixel_fifo_if #(parameter int WIDTH = 24) ();
  logic             push_valid;
  logic             push_ready;
  logic [WIDTH-1:0] push_data;
  logic             pop_valid;
  logic             pop_ready;
  logic [WIDTH-1:0] pop_data;
  logic             flush;

  // the buffer itself
  modport store (
    input  push_valid, push_data, pop_ready, flush,
    output push_ready, pop_valid, pop_data
  );

  // the scaler feeding it and draining it
  modport user (
    output push_valid, push_data, pop_ready, flush,
    input  push_ready, pop_valid, pop_data
  );
endinterface

//--- design/pixel_fifo.sv
`timescale 1ns/1ns
module pixel_fifo
  import capture_pkg::*;
#(
  parameter int WIDTH = PIX_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input  wire logic    i_clk,
  input  wire logic    i_reset,
  // both sides of the buffer
  pixel_fifo_if.store  bus
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             out_valid;
  logic [WIDTH-1:0] out_data;
  logic             push;
  logic             pop_mem;

  // read data always leaves through a register
  assign push          = bus.push_valid && bus.push_ready;
  assign pop_mem       = (count != '0) && (!out_valid || bus.pop_ready);
  assign bus.push_ready = (count != (AW+1)'(DEPTH));
  assign bus.pop_valid = out_valid;
  assign bus.pop_data  = out_data;

  // storage, no reset needed
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= bus.push_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge i_clk) begin
    if (i_reset || bus.flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop_mem) rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop_mem) count <= count + 1'b1;
      else if (!push && pop_mem) count <= count - 1'b1;
    end
  end

  // head register
  always_ff @(posedge i_clk) begin
    if (i_reset || bus.flush) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (pop_mem) begin
      out_valid <= 1'b1;
      out_data  <= mem[rd_ptr];
    end else if (bus.pop_ready) begin
      out_valid <= 1'b0;
    end
  end

endmodule // pixel_fifo

//--- design/camera_capture_control_resizer.sv
`timescale 1ns/1ns
module camera_capture_control_resizer
  import capture_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_reset,
  // software control
  input  wire logic                 i_soft_reset,
  input  wire logic                 i_record_mode,
  input  wire logic                 i_ctrl_write,
  input  wire logic                 i_start_stop,
  input  wire logic                 i_next_frame_write,
  input  wire logic [DELAY_W-1:0]   i_flash_delay,
  // camera timing and pixels
  input  wire logic                 i_cam_vertical_ref,
  input  wire logic                 i_vref_valid_high,
  input  wire logic                 i_cam_horizontal_ref,
  input  wire logic                 i_pix_valid,
  input  wire logic [PIX_W-1:0]     i_pix,
  // scaler settings
  input  wire logic                 i_scaler_enable,
  input  wire logic [1:0]           i_scale_mode,
  input  wire logic [RATE_W-1:0]    i_scale_rate,
  input  wire logic [COORD_W-1:0]   i_start_x,
  input  wire logic [COORD_W-1:0]   i_start_y,
  input  wire logic [COORD_W-1:0]   i_end_x,
  input  wire logic [COORD_W-1:0]   i_end_y,
  // scaled pixel stream out
  input  wire logic                 i_out_ready,
  output logic                      o_out_valid,
  output logic [PIX_W-1:0]          o_out_data,
  // status
  output logic [3:0]                o_state_id,
  output logic                      o_capturing,
  output logic                      o_scaler_frame_end,
  output logic                      o_overflow,
  output logic                      o_request_pending
);

  // ****************************************************************
  // helper functions
  // ****************************************************************

  // state id as seen by software, same code in both modes
  function automatic logic [3:0] id_of(input capture_state_t s);
    case (s)
      idle_state:           id_of = ID_IDLE;
      arming_state:         id_of = ID_ARMING;
      flash_delay_state:    id_of = ID_FLASH_DELAY;
      capturing_state:      id_of = ID_CAPTURING;
      repeat_capture_state: id_of = ID_REPEAT;
      paused_state:         id_of = ID_PAUSED;
      winding_down_state:   id_of = ID_WINDING;
      resume_state:         id_of = ID_RESUME;
      pre_final_state:      id_of = ID_PRE_FINAL;
      final_frame_state:    id_of = ID_FINAL_FRAME;
      final_pause_state:    id_of = ID_FINAL_PAUSE;
      default:              id_of = ID_IDLE;
    endcase
  endfunction

  // which states pass camera data on
  function automatic logic takes_data(input capture_state_t s,
                                      input logic rec);
    case (s)
      capturing_state:      takes_data = 1'b1;
      repeat_capture_state: takes_data = 1'b1;
      winding_down_state:   takes_data = rec;
      final_frame_state:    takes_data = 1'b1;
      default:              takes_data = 1'b0;
    endcase
  endfunction

  // log2 of a power-of-two square size
  function automatic logic [1:0] shift_of(input logic [RATE_W-1:0] n);
    case (n)
      4'h2:    shift_of = 2'h1;
      4'h4:    shift_of = 2'h2;
      4'h8:    shift_of = 2'h3;
      default: shift_of = 2'h0;
    endcase
  endfunction

  // centre index of a square, (n-1)/2
  function automatic logic [RATE_W-1:0] centre_of(
      input logic [RATE_W-1:0] n);
    centre_of = (n - 4'h1) >> 1;
  endfunction

  // ****************************************************************
  // frame and line timing
  // ****************************************************************
  logic           rst;
  logic           vref_prev;
  logic           href_prev;
  logic           vref_valid_now;
  logic           frame_event;
  logic           line_end;

  // software reset clears the whole block, resizer and machines
  assign rst = i_reset || i_soft_reset;

  // frame event: vertical reference leaving its valid level
  assign vref_valid_now = (i_cam_vertical_ref == i_vref_valid_high);
  assign frame_event    = vref_prev && !vref_valid_now;
  assign line_end       = href_prev && !i_cam_horizontal_ref;

  // edge history, held as valid-level flags
  always_ff @(posedge i_clk) begin
    if (rst) begin
      vref_prev <= 1'b0;
      href_prev <= 1'b0;
    end else begin
      vref_prev <= vref_valid_now;
      href_prev <= i_cam_horizontal_ref;
    end
  end

  // ****************************************************************
  // software strobes
  // ****************************************************************
  logic start_on;
  logic start_off;

  assign start_on  = i_ctrl_write && i_start_stop;
  assign start_off = i_ctrl_write && !i_start_stop;

  // ****************************************************************
  // capture control machine
  // ****************************************************************
  capture_state_t       state;
  capture_state_t       next_state;
  logic [DELAY_W-1:0]   delay_count;
  logic                 repeat_taken;

  assign repeat_taken = (state == capturing_state) && o_request_pending
                        && !i_record_mode;

  // transitions; frame-driven moves keep whole frames intact
  always_comb begin
    next_state = state;
    case (state)
      idle_state: begin
        if (start_on) next_state = arming_state;
      end
      arming_state: begin
        if (frame_event) begin
          next_state = i_record_mode ? capturing_state
                                     : flash_delay_state;
        end
      end
      flash_delay_state: begin
        if (frame_event && delay_count <= 8'h01) begin
          next_state = capturing_state;
        end
      end
      capturing_state: begin
        if (i_record_mode) begin
          if (start_off) next_state = winding_down_state;
          else if (o_scaler_frame_end) begin
            next_state = paused_state;
          end
        end else if (o_request_pending) begin
          next_state = repeat_capture_state;
        end else if (frame_event) begin
          next_state = paused_state;
        end
      end
      repeat_capture_state: begin
        if (frame_event) next_state = capturing_state;
      end
      paused_state: begin
        if (i_record_mode) begin
          if (start_off) next_state = pre_final_state;
          else if (frame_event) next_state = capturing_state;
        end else if (start_off) begin
          next_state = winding_down_state;
        end else if (start_on) begin
          next_state = resume_state;
        end
      end
      winding_down_state: begin
        if (i_record_mode) begin
          if (o_scaler_frame_end) next_state = idle_state;
        end else if (frame_event) begin
          next_state = idle_state;
        end
      end
      resume_state: begin
        if (frame_event) next_state = capturing_state;
      end
      pre_final_state: begin
        if (frame_event) next_state = final_frame_state;
      end
      final_frame_state: begin
        if (o_scaler_frame_end) next_state = final_pause_state;
      end
      final_pause_state: begin
        if (frame_event) next_state = idle_state;
      end
      default: next_state = idle_state;
    endcase
  end

  // state register and its registered views
  always_ff @(posedge i_clk) begin
    if (rst) begin
      state       <= idle_state;
      o_state_id  <= ID_IDLE;
      o_capturing <= 1'b0;
    end else begin
      state       <= next_state;
      o_state_id  <= id_of(next_state);
      o_capturing <= takes_data(next_state, i_record_mode);
    end
  end

  // flash delay, loaded on the way in, one step per frame
  always_ff @(posedge i_clk) begin
    if (rst) begin
      delay_count <= '0;
    end else if (state == arming_state && frame_event) begin
      delay_count <= i_flash_delay;
    end else if (state == flash_delay_state && frame_event
                 && delay_count != '0) begin
      delay_count <= delay_count - 1'b1;
    end
  end

  // pending next-frame request; a new write beats the consume
  always_ff @(posedge i_clk) begin
    if (rst) begin
      o_request_pending <= 1'b0;
    end else if (i_next_frame_write) begin
      o_request_pending <= 1'b1;
    end else if (repeat_taken) begin
      o_request_pending <= 1'b0;
    end
  end

  // ****************************************************************
  // crop window
  // ****************************************************************
  logic [COORD_W-1:0] pos_x;
  logic [COORD_W-1:0] pos_y;
  logic               row_in;
  logic               in_win;
  logic               take_pix;

  // pixels already come one per position, so crop is per pixel
  assign row_in   = (pos_y >= i_start_y) && (pos_y <= i_end_y);
  assign in_win   = row_in && (pos_x >= i_start_x)
                    && (pos_x <= i_end_x);
  assign take_pix = i_pix_valid && in_win && i_scaler_enable;

  // position from the upper-left corner of each frame
  always_ff @(posedge i_clk) begin
    if (rst || frame_event) begin
      pos_x <= '0;
      pos_y <= '0;
    end else if (line_end) begin
      pos_x <= '0;
      pos_y <= pos_y + 1'b1;
    end else if (i_pix_valid) begin
      pos_x <= pos_x + 1'b1;
    end
  end

  // ****************************************************************
  // scaling
  // ****************************************************************
  logic [RATE_W-1:0] rate;
  logic [RATE_W-1:0] centre;
  logic              avg_mode;
  logic [RATE_W-1:0] hph;
  logic [RATE_W-1:0] vph;
  logic              centre_row;
  logic [SUM_W-1:0]  acc [3];
  logic [SUM_W-1:0]  sum [3];
  logic              emit;
  logic [PIX_W-1:0]  emit_data;
  logic              last_pix;

  // no-scaling ignores the rate; odd ratios always sample
  assign rate     = (i_scale_mode == SCALE_NONE) ? 4'h1 : i_scale_rate;
  assign centre   = centre_of(rate);
  assign avg_mode = (i_scale_mode == SCALE_AVERAGE)
                    && (shift_of(rate) != 2'h0);
  assign centre_row = (vph == centre);
  assign last_pix = take_pix && pos_x == i_end_x
                    && pos_y == i_end_y;

  // running sums of the centre line, one per colour channel
  always_comb begin
    for (int c = 0; c < 3; c++) begin
      sum[c] = acc[c] + SUM_W'(i_pix[c*CHAN_W +: CHAN_W]);
    end
  end

  // pick or average one pixel per square
  always_comb begin
    emit      = 1'b0;
    emit_data = i_pix;
    if (take_pix && centre_row) begin
      if (avg_mode) begin
        emit = (hph == rate - 4'h1);
        for (int c = 0; c < 3; c++) begin
          emit_data[c*CHAN_W +: CHAN_W] =
            CHAN_W'(sum[c] >> shift_of(rate));
        end
      end else begin
        emit = (hph == centre);
      end
    end
  end

  // horizontal phase runs per cropped pixel, vertical per cropped line
  always_ff @(posedge i_clk) begin
    if (rst || frame_event) begin
      hph <= '0;
      vph <= '0;
    end else if (line_end) begin
      hph <= '0;
      if (row_in) vph <= (vph >= rate - 4'h1) ? 4'h0 : vph + 4'h1;
    end else if (take_pix) begin
      hph <= (hph >= rate - 4'h1) ? 4'h0 : hph + 4'h1;
    end
  end

  // accumulator restarts at each square edge
  always_ff @(posedge i_clk) begin
    if (rst || frame_event || line_end) begin
      for (int c = 0; c < 3; c++) acc[c] <= '0;
    end else if (take_pix && centre_row) begin
      for (int c = 0; c < 3; c++) begin
        acc[c] <= (hph == rate - 4'h1) ? '0 : sum[c];
      end
    end
  end

  // frame end of the scaler, last cropped pixel seen
  always_ff @(posedge i_clk) begin
    if (rst) begin
      o_scaler_frame_end <= 1'b0;
    end else begin
      o_scaler_frame_end <= last_pix;
    end
  end

  // ****************************************************************
  // buffer in front of the output
  // ****************************************************************
  pixel_fifo_if #(.WIDTH(PIX_W)) fifo_bus ();

  logic             push_valid;
  logic [PIX_W-1:0] push_data;

  // the camera cannot be stalled, so a full buffer drops and flags
  assign fifo_bus.push_valid = push_valid;
  assign fifo_bus.push_data  = push_data;
  assign fifo_bus.pop_ready  = i_scaler_enable
                               && (!o_out_valid || i_out_ready);
  assign fifo_bus.flush      = !i_scaler_enable;

  pixel_fifo #(
    .WIDTH (PIX_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .i_clk   (i_clk),
    .i_reset (rst),
    .bus     (fifo_bus)
  );

  // scaled pixels enter only while the machine captures
  always_ff @(posedge i_clk) begin
    if (rst) begin
      push_valid <= 1'b0;
      push_data  <= '0;
    end else if (push_valid && !fifo_bus.push_ready) begin
      push_valid <= push_valid;
    end else begin
      push_valid <= emit && takes_data(state, i_record_mode);
      push_data  <= emit_data;
    end
  end

  // overflow is sticky until reset; new pixels lost while stalled
  always_ff @(posedge i_clk) begin
    if (rst) begin
      o_overflow <= 1'b0;
    end else if (push_valid && !fifo_bus.push_ready && emit) begin
      o_overflow <= 1'b1;
    end
  end

  // output register; disable drops valid in the same edge
  always_ff @(posedge i_clk) begin
    if (rst || !i_scaler_enable) begin
      o_out_valid <= 1'b0;
      o_out_data  <= '0;
    end else if (!o_out_valid || i_out_ready) begin
      o_out_valid <= fifo_bus.pop_valid;
      o_out_data  <= fifo_bus.pop_data;
    end
  end

endmodule // camera_capture_control_resizer

//--- tb/cam_model.sv
`timescale 1ns/1ns
module cam_model (
  // clock and level sense
  input  wire logic        i_clk,
  input  wire logic        i_valid_high,
  // camera timing and pixels
  output logic             o_vref,
  output logic             o_href,
  output logic             o_pix_valid,
  output logic [23:0]      o_pix
);
  // ********************************************************
  // free-running 8 x 4 frame, one full pixel per cycle
  // ********************************************************
  initial begin
    o_vref = 1'b0;
    o_href = 1'b0;
    o_pix_valid = 1'b0;
    o_pix = 24'h000000;
    forever begin
      // blanking: the idle bus toggles so stale data cannot pass
      repeat (10) begin
        @(negedge i_clk);
        o_pix = ~o_pix;
      end
      o_vref = i_valid_high;
      for (int y = 0; y < 4; y++) begin
        for (int x = 0; x < 8; x++) begin
          @(negedge i_clk);
          o_href = 1'b1;
          o_pix_valid = 1'b1;
          o_pix = {8'(x + 16 * y), 8'(y), 8'(x)};
        end
        repeat (2) begin
          @(negedge i_clk);
          o_href = 1'b0;
          o_pix_valid = 1'b0;
          o_pix = ~o_pix;
        end
      end
      o_vref = ~i_valid_high;
    end
  end
endmodule // cam_model

//--- tb/capture_props.sv
`timescale 1ns/1ns
module capture_props #(parameter int DEPTH = 16) (
  // clock, reset and control
  input wire logic       i_clk,
  input wire logic       i_reset,
  input wire logic       i_soft_reset,
  input wire logic       i_record_mode,
  input wire logic       i_ctrl_write,
  input wire logic       i_start_stop,
  input wire logic       i_next_frame_write,
  input wire logic       i_cam_vertical_ref,
  input wire logic       i_vref_valid_high,
  input wire logic       i_scaler_enable,
  input wire logic       i_out_ready,
  // observed outputs
  input wire logic       o_out_valid,
  input wire logic [3:0] o_state_id,
  input wire logic       o_capturing,
  input wire logic       o_request_pending
);
  logic was_ok, fe, wr1, wr0, enc;
  // frame event rebuilt from the raw level, independent of the design
  always_ff @(posedge i_clk) begin
    was_ok <= !(i_reset || i_soft_reset)
              && (i_cam_vertical_ref == i_vref_valid_high);
  end
  assign fe = was_ok && (i_cam_vertical_ref != i_vref_valid_high);
  assign wr1 = i_ctrl_write && i_start_stop;
  assign wr0 = i_ctrl_write && !i_start_stop;
  assign enc = !i_record_mode;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset || i_soft_reset);

  property p_rst; disable iff (1'b0) i_reset || i_soft_reset |=>
    o_state_id == 4'h0 && !o_out_valid && !o_request_pending; endproperty
  a_rst: assert property (p_rst) else $error("reset");
  property p_start; o_state_id == 4'h0 && wr1 |=> o_state_id == 4'h1;
  endproperty
  a_start: assert property (p_start) else $error("start");
  property p_dark; o_state_id inside {4'h0, 4'h1, 4'h3, 4'h6, 4'h5,
    4'he, 4'hd} || (enc && o_state_id == 4'h4) |-> !o_capturing; endproperty
  a_dark: assert property (p_dark) else $error("dark");
  property p_hold7; enc && o_state_id == 4'h7 && !fe && !i_ctrl_write
    && !o_request_pending |=> o_state_id == 4'h7; endproperty
  a_hold7: assert property (p_hold7) else $error("left early");
  property p_repeat; enc && o_state_id == 4'h7 && o_request_pending && fe
    |=> o_state_id == 4'hb ##1 o_state_id == 4'hb; endproperty
  a_repeat: assert property (p_repeat) else $error("repeat");
  property p_pause; enc && o_state_id == 4'h7 && !o_request_pending &&
    !i_next_frame_write && fe |=> o_state_id == 4'h6; endproperty
  a_pause: assert property (p_pause) else $error("pause");
  property p_wind; o_state_id == 4'h6 && wr0 && !fe |=>
    o_state_id == ($past(i_record_mode) ? 4'he : 4'h4); endproperty
  a_wind: assert property (p_wind) else $error("wind");
  property p_resume; enc && o_state_id == 4'h6 && wr1 && !fe
    |=> o_state_id == 4'h5; endproperty
  a_resume: assert property (p_resume) else $error("resume");
  property p_off; !i_scaler_enable |=> !o_out_valid; endproperty
  a_off: assert property (p_off) else $error("output on");

  // main scenarios reached
  c_repeat: cover property (o_state_id == 4'hb);
  c_final: cover property (o_state_id == 4'hf);
  c_stall: cover property (o_out_valid && !i_out_ready);
endmodule // capture_props

bind camera_capture_control_resizer capture_props #(.DEPTH(DEPTH)) u_props (
  .i_clk, .i_reset, .i_soft_reset, .i_record_mode, .i_ctrl_write,
  .i_start_stop, .i_next_frame_write, .i_cam_vertical_ref,
  .i_vref_valid_high, .i_scaler_enable, .i_out_ready, .o_out_valid,
  .o_state_id, .o_capturing, .o_request_pending);

//--- tb/tb.sv
`timescale 1ns/1ns
module tb;
  import capture_pkg::*;
  // ********************************************************
  // signals
  // ********************************************************
  logic i_clk, i_reset, i_soft_reset, i_record_mode, i_ctrl_write;
  logic i_start_stop, i_next_frame_write, i_cam_vertical_ref;
  logic i_vref_valid_high, i_cam_horizontal_ref, i_pix_valid;
  logic i_scaler_enable, i_out_ready, o_out_valid, o_scaler_frame_end;
  logic o_capturing, o_overflow, o_request_pending, rdy_en, was_ok;
  logic [DELAY_W-1:0] i_flash_delay;
  logic [PIX_W-1:0]   i_pix, o_out_data;
  logic [1:0]         i_scale_mode;
  logic [RATE_W-1:0]  i_scale_rate;
  logic [COORD_W-1:0] i_start_x, i_start_y, i_end_x, i_end_y;
  logic [3:0]         o_state_id;
  logic [PIX_W-1:0]   q[$];
  int                 bad_count, check_count, fc, cyc;

  camera_capture_control_resizer #(.DEPTH(FIFO_DEPTH)) dut (
    .i_clk, .i_reset, .i_soft_reset, .i_record_mode, .i_ctrl_write,
    .i_start_stop, .i_next_frame_write, .i_flash_delay, .i_cam_vertical_ref,
    .i_vref_valid_high, .i_cam_horizontal_ref, .i_pix_valid, .i_pix,
    .i_scaler_enable, .i_scale_mode, .i_scale_rate, .i_start_x, .i_start_y,
    .i_end_x, .i_end_y, .i_out_ready, .o_out_valid, .o_out_data,
    .o_state_id, .o_capturing, .o_scaler_frame_end, .o_overflow,
    .o_request_pending);
  cam_model cam (.i_clk, .i_valid_high(i_vref_valid_high),
    .o_vref(i_cam_vertical_ref), .o_href(i_cam_horizontal_ref),
    .o_pix_valid(i_pix_valid), .o_pix(i_pix));

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  // own frame count, output collector and hang guard
  always @(posedge i_clk) begin
    cyc++;
    if (was_ok && i_cam_vertical_ref !== i_vref_valid_high) fc++;
    was_ok = (i_cam_vertical_ref === i_vref_valid_high);
    if (o_out_valid && i_out_ready) q.push_back(o_out_data);
    if (cyc == 20000) begin
      bad_count++;
      $display("ERROR %0t timeout", $time);
      stop_test();
    end
  end
  // downstream stalls one cycle in three so the buffer must hold data
  always @(negedge i_clk) i_out_ready <= rdy_en && (cyc % 3 != 0);

  // ********************************************************
  // shared tasks
  // ********************************************************
  task automatic check(logic [23:0] got, logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic pulse(ref logic s);
    @(negedge i_clk);
    s = 1'b1;
    @(negedge i_clk);
    s = 1'b0;
  endtask
  task automatic ctrl(logic v);
    i_start_stop = v;
    pulse(i_ctrl_write);
  endtask
  task automatic wait_id(logic [3:0] id);
    for (int i = 0; i < 400 && o_state_id !== id; i++) @(negedge i_clk);
    check(o_state_id, id);
  endtask
  task automatic stop_test();
    if (bad_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ********************************************************
  // scenarios
  // ********************************************************
  task automatic t_encode();
    int a;
    ctrl(1'b1);
    check(o_state_id, 4'h1);
    wait_id(4'h3);
    a = fc;
    wait_id(4'h7);
    check(24'(fc - a), 24'h000002);
    pulse(i_next_frame_write);
    check(o_request_pending, 1'b1);
    wait_id(4'hb);
    wait_id(4'h7);
    wait_id(4'h6);
    check(o_capturing, 1'b0);
    ctrl(1'b1);
    check(o_state_id, 4'h5);
    wait_id(4'h7);
    wait_id(4'h6);
    ctrl(1'b0);
    check(o_state_id, 4'h4);
    wait_id(4'h0);
    ctrl(1'b1);
    wait_id(4'h3);
    pulse(i_soft_reset);
    check(o_state_id, 4'h0);
  endtask
  task automatic t_stream(logic [1:0] m, int n, int x0, int y0, int x1,
                          int y1);
    int k;
    repeat (30) @(negedge i_clk);
    while (i_cam_vertical_ref === i_vref_valid_high) @(negedge i_clk);
    i_scale_mode = m;
    i_scale_rate = RATE_W'(n);
    i_start_x = COORD_W'(x0);
    i_start_y = COORD_W'(y0);
    i_end_x = COORD_W'(x1);
    i_end_y = COORD_W'(y1);
    q.delete();
    ctrl(1'b1);
    wait_id(4'h7);
    wait_id(4'h6);
    repeat (30) @(negedge i_clk);
    ctrl(1'b0);
    wait_id(4'h0);
    k = 0;
    for (int y = y0; y <= y1; y++)
      for (int x = x0; x <= x1; x++)
        if (m == SCALE_NONE || ((x - x0) % n == (n - 1) / 2 &&
            (y - y0) % n == (n - 1) / 2)) begin
          check(q[k], {8'(x + 16 * y), 8'(y), 8'(x)});
          k++;
        end
    check(24'(q.size()), 24'(k));
  endtask
  task automatic t_overflow();
    rdy_en = 1'b0;
    ctrl(1'b1);
    wait_id(4'h7);
    wait_id(4'h6);
    check(o_overflow, 1'b1);
    check(o_out_valid, 1'b1);
    i_scaler_enable = 1'b0;
    @(negedge i_clk);
    check(o_out_valid, 1'b0);
    i_scaler_enable = 1'b1;
    rdy_en = 1'b1;
    ctrl(1'b0);
    wait_id(4'h0);
    pulse(i_reset);
    check(o_overflow, 1'b0);
  endtask
  task automatic t_record();
    i_record_mode = 1'b1;
    i_end_y = 11'h002;
    ctrl(1'b1);
    check(o_state_id, 4'h1);
    wait_id(4'h7);
    wait_id(4'h6);
    ctrl(1'b0);
    check(o_state_id, 4'he);
    wait_id(4'hf);
    wait_id(4'hd);
    wait_id(4'h0);
    ctrl(1'b1);
    wait_id(4'h7);
    ctrl(1'b0);
    check(o_state_id, 4'h4);
    wait_id(4'h0);
    i_record_mode = 1'b0;
  endtask

  initial begin
    {i_reset, i_vref_valid_high, i_scaler_enable, rdy_en} = 4'hf;
    {i_soft_reset, i_record_mode, i_ctrl_write} = 3'h0;
    {i_start_stop, i_next_frame_write, i_out_ready} = 3'h0;
    {i_start_x, i_start_y, i_end_x, i_end_y} = {22'h0, 11'h7, 11'h3};
    i_scale_mode = SCALE_NONE;
    i_scale_rate = 4'h1;
    i_flash_delay = 8'h02;
    repeat (8) @(negedge i_clk);
    i_reset = 1'b0;
    t_encode();
    t_stream(SCALE_NONE, 1, 0, 0, 7, 3);
    t_overflow();
    t_record();
    t_stream(SCALE_SAMPLE, 2, 0, 0, 7, 3);
    t_stream(SCALE_SAMPLE, 4, 0, 0, 7, 3);
    t_stream(SCALE_SAMPLE, 3, 1, 0, 6, 2);
    t_stream(SCALE_AVERAGE, 4, 0, 0, 7, 3);
    t_stream(SCALE_AVERAGE, 3, 1, 0, 6, 2);
    stop_test();
  end
endmodule // tb
